//--- include/timer_pkg.sv
// shared constants and types for the dual timer/counter block
package timer_pkg;

  // oscillator periods (core_clk cycles) per machine cycle
  localparam int OSC_PER_MACHINE_CYCLE = 6;
  localparam int CLK_PERIOD_NS         = 10;
  localparam logic [2:0] MC_LAST = 3'(OSC_PER_MACHINE_CYCLE - 1);

  // avalon byte address width; register byte address is four times the index
  localparam int ADDR_W = 10;

  // register indices
  localparam logic [7:0] IDX_RUN_FLAG   = 8'h88;
  localparam logic [7:0] IDX_MODE_CFG   = 8'h89;
  localparam logic [7:0] IDX_LOW_ZERO   = 8'h8a;
  localparam logic [7:0] IDX_LOW_ONE    = 8'h8b;
  localparam logic [7:0] IDX_UPPER_ZERO = 8'h8c;
  localparam logic [7:0] IDX_UPPER_ONE  = 8'h8d;

  // reset values
  localparam logic [7:0] RUN_FLAG_RST = 8'h00;
  localparam logic [7:0] MODE_CFG_RST = 8'h00;
  localparam logic [7:0] COUNT_RST    = 8'h00;

  typedef enum logic [1:0] {
    MODE_PRESCALED13 = 2'b00,
    MODE_CASCADE16   = 2'b01,
    MODE_RELOAD8     = 2'b10,
    MODE_SPLIT       = 2'b11
  } mode_t;

  // one nibble per unit: bit 3 pin qualify, bit 2 count source, bits 1:0 mode
  typedef struct packed {
    logic  pin_qualify;
    logic  cnt_src;
    mode_t mode;
  } unit_cfg_t;

  // mode_config_reg: unit one in bits 7:4, unit zero in bits 3:0
  typedef struct packed {
    unit_cfg_t one;
    unit_cfg_t zero;
  } mode_config_t;

  // run_flag_reg, bit 7 down to bit 0
  typedef struct packed {
    logic overflow_flag_one;
    logic run_bit_one;
    logic overflow_flag_zero;
    logic run_bit_zero;
    logic ext_irq_flag_one;
    logic ext_irq_type_one;
    logic ext_irq_flag_zero;
    logic ext_irq_type_zero;
  } run_flag_t;

  // hardware clear strobes from the interrupt controller on vectoring
  typedef struct packed {
    logic overflow_one;
    logic overflow_zero;
    logic ext_irq_one;
    logic ext_irq_zero;
  } vector_ack_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
    logic       ovf;
  } count_step_t;

  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

endpackage

//--- hw/pin_sampler.sv
// two-flop synchroniser plus once-per-machine-cycle sampler for one pin
`timescale 1ns/1ps
module pin_sampler (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin,
  input  wire logic mc_tick,
  output logic      level,
  output logic      fall
);

  logic sync_a;
  logic sync_b;
  logic sample;
  logic next_sample;
  logic next_fall;

  // fall holds for a whole machine cycle, so it is consumed on the next tick
  always_comb begin
    next_sample = sample;
    next_fall   = fall;
    if (mc_tick) begin
      next_sample = sync_b;
      next_fall   = sample & ~sync_b;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sample <= 1'b1;
      fall   <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      sample <= next_sample;
      fall   <= next_fall;
    end
  end

  assign level = sync_b;

endmodule

//--- hw/dual_timer_counter.sv
// two timer/counter units with run/flag and mode registers on avalon-mm
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
module dual_timer_counter (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic [timer_pkg::ADDR_W-1:0] address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  output logic [31:0]                      readdata,
  output logic                             waitrequest,
  input  wire logic                        count_pin_zero,
  input  wire logic                        count_pin_one,
  input  wire logic                        ext_irq_pin_zero,
  input  wire logic                        ext_irq_pin_one,
  input  wire timer_pkg::vector_ack_t      vector_ack,
  output logic                             overflow_pulse_zero,
  output logic                             overflow_pulse_one,
  output timer_pkg::run_flag_t             run_flag_reg
);

  timer_pkg::mode_config_t mode_config_reg;
  timer_pkg::mode_config_t next_mode_config;
  timer_pkg::run_flag_t    next_run_flag;
  timer_pkg::bus_state_t   bus_state;
  timer_pkg::bus_state_t   next_bus_state;
  timer_pkg::count_step_t  step_zero;
  timer_pkg::count_step_t  step_one;
  logic [31:0] next_readdata;
  logic [7:0]  read_mux;
  logic [7:0]  reg_idx;
  logic        idx_ok;
  logic        wr_ok;
  logic [2:0]  mc_count;
  logic [2:0]  next_mc_count;
  logic        mc_tick;
  logic [7:0]  lower_byte_unit_zero;
  logic [7:0]  upper_byte_unit_zero;
  logic [7:0]  lower_byte_unit_one;
  logic [7:0]  upper_byte_unit_one;
  logic [7:0]  next_lower_zero;
  logic [7:0]  next_upper_zero;
  logic [7:0]  next_lower_one;
  logic [7:0]  next_upper_one;
  logic [8:0]  upper_split_sum;
  logic        cnt_fall_zero;
  logic        cnt_fall_one;
  logic        irq_level_zero;
  logic        irq_level_one;
  logic        irq_fall_zero;
  logic        irq_fall_one;
  logic        split_zero;
  logic        enable_zero;
  logic        enable_one;
  logic        inc_zero;
  logic        inc_one;
  logic        inc_upper_split;
  logic        ovf_zero;
  logic        ovf_one;
  logic        ovf_upper_split;
  logic        ext_set_zero;
  logic        ext_set_one;

  // ---------------- machine cycle ----------------
  always_comb begin
    next_mc_count = (mc_count == timer_pkg::MC_LAST) ? 3'h0 : mc_count + 3'h1;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mc_count <= 3'h0;
    end else begin
      mc_count <= next_mc_count;
    end
  end

  assign mc_tick = (mc_count == timer_pkg::MC_LAST);

  // ---------------- pins ----------------
  pin_sampler cnt_pin_zero_smp (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (count_pin_zero),
    .mc_tick  (mc_tick),
    .level    (),
    .fall     (cnt_fall_zero)
  );

  pin_sampler cnt_pin_one_smp (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (count_pin_one),
    .mc_tick  (mc_tick),
    .level    (),
    .fall     (cnt_fall_one)
  );

  pin_sampler irq_pin_zero_smp (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (ext_irq_pin_zero),
    .mc_tick  (mc_tick),
    .level    (irq_level_zero),
    .fall     (irq_fall_zero)
  );

  pin_sampler irq_pin_one_smp (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (ext_irq_pin_one),
    .mc_tick  (mc_tick),
    .level    (irq_level_one),
    .fall     (irq_fall_one)
  );

  // ---------------- count enables ----------------
  assign split_zero = (mode_config_reg.zero.mode == timer_pkg::MODE_SPLIT);
  assign enable_zero = run_flag_reg.run_bit_zero &
                       (~mode_config_reg.zero.pin_qualify | irq_level_zero);
  // with unit zero split, unit one is started only by leaving its own mode three
  assign enable_one = (run_flag_reg.run_bit_one | split_zero) &
                      (mode_config_reg.one.mode != timer_pkg::MODE_SPLIT) &
                      (~mode_config_reg.one.pin_qualify | irq_level_one);
  assign inc_zero = mc_tick & enable_zero &
                    (mode_config_reg.zero.cnt_src ? cnt_fall_zero : 1'b1);
  assign inc_one = mc_tick & enable_one &
                   (mode_config_reg.one.cnt_src ? cnt_fall_one : 1'b1);
  assign inc_upper_split = mc_tick & split_zero & run_flag_reg.run_bit_one;

  // one step of a unit; split mode only steps the lower byte here
  function automatic timer_pkg::count_step_t count_step(input timer_pkg::mode_t m,
                                                        input logic [7:0] upper,
                                                        input logic [7:0] lower);
    timer_pkg::count_step_t s;
    logic [13:0] w13;
    logic [16:0] w16;
    logic [8:0]  w8;
    s.upper = upper;
    s.lower = lower;
    s.ovf   = 1'b0;
    w13 = {1'b0, upper, lower[4:0]} + 14'h0001;
    w16 = {1'b0, upper, lower} + 17'h00001;
    w8  = {1'b0, lower} + 9'h001;
    case (m)
      timer_pkg::MODE_PRESCALED13: begin
        // bits 7:5 of the lower byte carry no count and are left alone
        s.upper = w13[12:5];
        s.lower = {lower[7:5], w13[4:0]};
        s.ovf   = w13[13];
      end
      timer_pkg::MODE_CASCADE16: begin
        s.upper = w16[15:8];
        s.lower = w16[7:0];
        s.ovf   = w16[16];
      end
      timer_pkg::MODE_RELOAD8: begin
        s.lower = w8[8] ? upper : w8[7:0];
        s.ovf   = w8[8];
      end
      default: begin
        s.lower = w8[7:0];
        s.ovf   = w8[8];
      end
    endcase
    return s;
  endfunction

  // ---------------- count registers ----------------
  always_comb begin
    step_zero = count_step(mode_config_reg.zero.mode, upper_byte_unit_zero,
                           lower_byte_unit_zero);
    step_one  = count_step(mode_config_reg.one.mode, upper_byte_unit_one,
                           lower_byte_unit_one);
    upper_split_sum = {1'b0, upper_byte_unit_zero} + 9'h001;
    next_lower_zero = lower_byte_unit_zero;
    next_upper_zero = upper_byte_unit_zero;
    next_lower_one  = lower_byte_unit_one;
    next_upper_one  = upper_byte_unit_one;
    ovf_zero        = 1'b0;
    ovf_one         = 1'b0;
    ovf_upper_split = 1'b0;
    if (inc_zero) begin
      next_lower_zero = step_zero.lower;
      if (!split_zero) begin
        next_upper_zero = step_zero.upper;
      end
      ovf_zero = step_zero.ovf;
    end
    if (inc_upper_split) begin
      next_upper_zero = upper_split_sum[7:0];
      ovf_upper_split = upper_split_sum[8];
    end
    if (inc_one) begin
      next_lower_one = step_one.lower;
      next_upper_one = step_one.upper;
      ovf_one        = step_one.ovf;
    end
    // a software write wins over a count in the same cycle
    if (wr_ok) begin
      case (reg_idx)
        timer_pkg::IDX_LOW_ZERO:   next_lower_zero = writedata[7:0];
        timer_pkg::IDX_UPPER_ZERO: next_upper_zero = writedata[7:0];
        timer_pkg::IDX_LOW_ONE:    next_lower_one  = writedata[7:0];
        timer_pkg::IDX_UPPER_ONE:  next_upper_one  = writedata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lower_byte_unit_zero <= timer_pkg::COUNT_RST;
      upper_byte_unit_zero <= timer_pkg::COUNT_RST;
      lower_byte_unit_one  <= timer_pkg::COUNT_RST;
      upper_byte_unit_one  <= timer_pkg::COUNT_RST;
      overflow_pulse_zero  <= 1'b0;
      overflow_pulse_one   <= 1'b0;
    end else begin
      lower_byte_unit_zero <= next_lower_zero;
      upper_byte_unit_zero <= next_upper_zero;
      lower_byte_unit_one  <= next_lower_one;
      upper_byte_unit_one  <= next_upper_one;
      overflow_pulse_zero  <= ovf_zero;
      overflow_pulse_one   <= ovf_one;
    end
  end

  // ---------------- control registers ----------------
  // level mode re-arms every machine cycle while the pin stays low
  assign ext_set_zero = run_flag_reg.ext_irq_type_zero ? irq_fall_zero & mc_tick
                                                       : mc_tick & ~irq_level_zero;
  assign ext_set_one = run_flag_reg.ext_irq_type_one ? irq_fall_one & mc_tick
                                                     : mc_tick & ~irq_level_one;

  always_comb begin
    next_run_flag    = run_flag_reg;
    next_mode_config = mode_config_reg;
    if (wr_ok && reg_idx == timer_pkg::IDX_RUN_FLAG) begin
      next_run_flag = timer_pkg::run_flag_t'(writedata[7:0]);
    end
    if (wr_ok && reg_idx == timer_pkg::IDX_MODE_CFG) begin
      next_mode_config = timer_pkg::mode_config_t'(writedata[7:0]);
    end
    if (vector_ack.overflow_zero) next_run_flag.overflow_flag_zero = 1'b0;
    if (vector_ack.overflow_one) next_run_flag.overflow_flag_one = 1'b0;
    if (vector_ack.ext_irq_zero) next_run_flag.ext_irq_flag_zero = 1'b0;
    if (vector_ack.ext_irq_one) next_run_flag.ext_irq_flag_one = 1'b0;
    // hardware sets come last so an event never loses to a clear
    if (ovf_zero) next_run_flag.overflow_flag_zero = 1'b1;
    if (split_zero ? ovf_upper_split : ovf_one) begin
      next_run_flag.overflow_flag_one = 1'b1;
    end
    if (ext_set_zero) next_run_flag.ext_irq_flag_zero = 1'b1;
    if (ext_set_one) next_run_flag.ext_irq_flag_one = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_flag_reg    <= timer_pkg::run_flag_t'(timer_pkg::RUN_FLAG_RST);
      mode_config_reg <= timer_pkg::mode_config_t'(timer_pkg::MODE_CFG_RST);
    end else begin
      run_flag_reg    <= next_run_flag;
      mode_config_reg <= next_mode_config;
    end
  end

  // ---------------- avalon-mm slave ----------------
  // one wait state: data is muxed on the first cycle, answered on the second
  assign reg_idx = address[timer_pkg::ADDR_W-1:2];
  assign idx_ok  = (address[1:0] == 2'h0);
  assign wr_ok   = write & (bus_state == timer_pkg::BUS_ANSWER) & idx_ok;
  assign waitrequest = (read | write) & (bus_state == timer_pkg::BUS_IDLE);

  always_comb begin
    read_mux = 8'h00;
    if (idx_ok) begin
      case (reg_idx)
        timer_pkg::IDX_RUN_FLAG:   read_mux = run_flag_reg;
        timer_pkg::IDX_MODE_CFG:   read_mux = mode_config_reg;
        timer_pkg::IDX_LOW_ZERO:   read_mux = lower_byte_unit_zero;
        timer_pkg::IDX_UPPER_ZERO: read_mux = upper_byte_unit_zero;
        timer_pkg::IDX_LOW_ONE:    read_mux = lower_byte_unit_one;
        timer_pkg::IDX_UPPER_ONE:  read_mux = upper_byte_unit_one;
        default:                   read_mux = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_bus_state = timer_pkg::BUS_IDLE;
    next_readdata  = readdata;
    case (bus_state)
      timer_pkg::BUS_IDLE: begin
        if (read || write) begin
          next_bus_state = timer_pkg::BUS_ANSWER;
          next_readdata  = read ? {24'h000000, read_mux} : 32'h00000000;
        end
      end
      timer_pkg::BUS_ANSWER: next_bus_state = timer_pkg::BUS_IDLE;
      default:               next_bus_state = timer_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_state <= timer_pkg::BUS_IDLE;
      readdata  <= 32'h00000000;
    end else begin
      bus_state <= next_bus_state;
      readdata  <= next_readdata;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  tick_period_a: assert property (mc_tick |=> !mc_tick [*5] ##1 mc_tick)
    else $error("machine cycle is not six clocks");

  timer_step_a: assert property (inc_zero && !wr_ok && !mode_config_reg.zero.cnt_src &&
      mode_config_reg.zero.mode == timer_pkg::MODE_CASCADE16 |=>
      {upper_byte_unit_zero, lower_byte_unit_zero} ==
      16'($past({upper_byte_unit_zero, lower_byte_unit_zero}) + 16'h0001))
    else $error("sixteen-bit count did not step by one");

  pin_idle_a: assert property (mc_tick && mode_config_reg.zero.cnt_src && !cnt_fall_zero &&
      !wr_ok |=> $stable(lower_byte_unit_zero))
    else $error("counter moved without a sampled fall");

  gate_hold_a: assert property (mode_config_reg.zero.pin_qualify && !irq_level_zero &&
      !wr_ok |=> $stable(lower_byte_unit_zero))
    else $error("count moved while qualify pin low");

  reload_copy_a: assert property (inc_zero && !wr_ok && lower_byte_unit_zero == 8'hff &&
      mode_config_reg.zero.mode == timer_pkg::MODE_RELOAD8 |=>
      lower_byte_unit_zero == $past(upper_byte_unit_zero) &&
      $stable(upper_byte_unit_zero) && run_flag_reg.overflow_flag_zero)
    else $error("reload did not copy upper byte");

  prescale_hold_a: assert property (inc_zero && !wr_ok && lower_byte_unit_zero[4:0] != 5'h1f &&
      mode_config_reg.zero.mode == timer_pkg::MODE_PRESCALED13 |=>
      $stable(upper_byte_unit_zero))
    else $error("upper byte stepped before prescaler wrap");

  ovf_flag_a: assert property (overflow_pulse_zero |-> run_flag_reg.overflow_flag_zero ##1
      !overflow_pulse_zero)
    else $error("overflow pulse without flag or too long");

  unit_stop_a: assert property (mode_config_reg.one.mode == timer_pkg::MODE_SPLIT && !wr_ok
      |=> $stable({upper_byte_unit_one, lower_byte_unit_one}))
    else $error("unit one counted in mode three");

  // the run write owns the bus that cycle, so only a start could move the count
  run_start_a: assert property ($rose(run_flag_reg.run_bit_zero) |->
      $stable(lower_byte_unit_zero))
    else $error("starting run changed the count");

  bus_answer_a: assert property ((read || write) && waitrequest |=>
      !waitrequest ##1 bus_state == timer_pkg::BUS_IDLE)
    else $error("bus answer not after one wait state");

  split_cover: cover property (split_zero && ovf_upper_split);
  reload_cover: cover property (ovf_zero && mode_config_reg.zero.mode == timer_pkg::MODE_RELOAD8);
  edge_cover: cover property (ext_set_one && run_flag_reg.ext_irq_type_one);
  count_cover: cover property (inc_one && mode_config_reg.one.cnt_src);

endmodule

//--- tb/pin_source.sv
// external count pin source: falling-edge pulses on request
`timescale 1ns/1ps
module pin_source #(
  parameter int HALF = 12
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       go,
  input  wire logic [3:0] pulses,
  output logic            pin,
  output logic            busy
);
  logic [3:0] left;
  logic [4:0] cnt;
  assign busy = (left != 4'h0);
  // each level held two machine cycles, past the sync latency
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin <= 1'b1;
      left <= 4'h0;
      cnt <= 5'h00;
    end else if (go && !busy) begin
      left <= pulses;
      cnt <= 5'h00;
    end else if (busy) begin
      cnt <= cnt + 5'h01;
      if (cnt == 5'(HALF - 1)) begin
        cnt <= 5'h00;
        pin <= ~pin;
        if (!pin) begin
          left <= left - 4'h1;
        end
      end
    end
  end
endmodule

//--- tb/dual_timer_counter_four_modes_tb_top.sv
// register-level bench for the dual timer/counter
`timescale 1ns/1ps
module dual_timer_counter_four_modes_tb_top;
  logic                        core_clk;
  logic                        reset;
  logic [timer_pkg::ADDR_W-1:0] address;
  logic                        read;
  logic                        write;
  logic [31:0]                 writedata;
  logic [31:0]                 readdata;
  logic                        waitrequest;
  logic                        count_pin_zero;
  logic                        count_pin_one;
  logic                        ext_irq_pin_zero;
  logic                        ext_irq_pin_one;
  timer_pkg::vector_ack_t      vector_ack;
  logic                        overflow_pulse_zero;
  logic                        overflow_pulse_one;
  timer_pkg::run_flag_t        run_flag_reg;
  logic                        go;
  logic [3:0]                  pulses;
  logic                        busy;
  int                          fail_count;
  int                          checks_done;

  dual_timer_counter DUT (
    .core_clk(core_clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .count_pin_zero(count_pin_zero),
    .count_pin_one(count_pin_one), .ext_irq_pin_zero(ext_irq_pin_zero),
    .ext_irq_pin_one(ext_irq_pin_one), .vector_ack(vector_ack),
    .overflow_pulse_zero(overflow_pulse_zero),
    .overflow_pulse_one(overflow_pulse_one), .run_flag_reg(run_flag_reg)
  );
  pin_source src (
    .core_clk(core_clk), .reset(reset), .go(go), .pulses(pulses),
    .pin(count_pin_one), .busy(busy)
  );
  // both count pins share one source; only one unit at a time is set to count pin falls
  assign count_pin_zero = count_pin_one;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // one request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    write <= w;
    read <= ~w;
    writedata <= {24'h0, d};
    @(posedge core_clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    q = readdata[7:0];
    if (n >= 20) begin
      chk(8'h00, 8'h01, "bus timeout");
      close_out();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(idx, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string m);
    logic [7:0] q;
    bus(idx, 1'b0, 8'h00, q);
    chk(q, exp, m);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wait_ovf(input logic one, input int lim, output int n);
    n = 0;
    @(negedge core_clk);
    while ((one ? overflow_pulse_one : overflow_pulse_zero) !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= lim) begin
      chk(8'h00, 8'h01, "no overflow");
      close_out();
    end
    @(negedge core_clk);
    chk({7'h0, overflow_pulse_zero | overflow_pulse_one}, 8'h00, "pulse width");
    @(posedge core_clk);
  endtask

  task automatic pulse(input logic [3:0] k);
    int n;
    n = 0;
    go <= 1'b1;
    pulses <= k;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    while (busy !== 1'b0 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 400) begin
      chk(8'h00, 8'h01, "pin source stuck");
      close_out();
    end
    idle(24);
  endtask

  initial begin
    #1000000;
    fail_count++;
    $display("[FAIL] %0t run timeout", $time);
    close_out();
  end

  initial begin
    logic [7:0] q;
    int n;
    fail_count = 0;
    checks_done = 0;
    reset = 1'b1;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    ext_irq_pin_zero = 1'b1;
    ext_irq_pin_one = 1'b1;
    vector_ack = '0;
    go = 1'b0;
    pulses = 4'h0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd_chk(timer_pkg::IDX_RUN_FLAG, timer_pkg::RUN_FLAG_RST, "run reset");
    rd_chk(timer_pkg::IDX_MODE_CFG, timer_pkg::MODE_CFG_RST, "mode reset");
    rd_chk(8'h90, 8'h00, "unmapped");
    wr(timer_pkg::IDX_MODE_CFG, 8'ha5);
    rd_chk(timer_pkg::IDX_MODE_CFG, 8'ha5, "mode rw");
    $display("test registers done");
    // 193 ticks to wrap in 16 bits; 13 bits would wrap at once
    wr(timer_pkg::IDX_MODE_CFG, 8'h01);
    wr(timer_pkg::IDX_LOW_ZERO, 8'h3f);
    wr(timer_pkg::IDX_UPPER_ZERO, 8'hff);
    wr(timer_pkg::IDX_RUN_FLAG, 8'h10);
    wait_ovf(1'b0, 1300, n);
    chk(8'(n >= 1140 && n <= 1160), 8'h01, "16-bit rate");
    chk({7'h0, run_flag_reg.overflow_flag_zero}, 8'h01, "ovf flag");
    vector_ack <= 4'b0100;
    @(posedge core_clk);
    vector_ack <= '0;
    idle(2);
    chk({7'h0, run_flag_reg.overflow_flag_zero}, 8'h00, "ovf ack");
    $display("test cascade16 done");
    wr(timer_pkg::IDX_RUN_FLAG, 8'h00);
    wr(timer_pkg::IDX_MODE_CFG, 8'h00);
    wr(timer_pkg::IDX_LOW_ZERO, 8'hff);
    wr(timer_pkg::IDX_UPPER_ZERO, 8'hff);
    wr(timer_pkg::IDX_RUN_FLAG, 8'h10);
    wait_ovf(1'b0, 20, n);
    wr(timer_pkg::IDX_RUN_FLAG, 8'h00);
    rd_chk(timer_pkg::IDX_UPPER_ZERO, 8'h00, "m0 upper");
    bus(timer_pkg::IDX_LOW_ZERO, 1'b0, 8'h00, q);
    chk(q & 8'h1f, 8'h00, "m0 prescale");
    $display("test prescaled13 done");
    wr(timer_pkg::IDX_MODE_CFG, 8'h02);
    wr(timer_pkg::IDX_UPPER_ZERO, 8'ha0);
    wr(timer_pkg::IDX_LOW_ZERO, 8'hff);
    wr(timer_pkg::IDX_RUN_FLAG, 8'h10);
    wait_ovf(1'b0, 20, n);
    wr(timer_pkg::IDX_RUN_FLAG, 8'h00);
    rd_chk(timer_pkg::IDX_LOW_ZERO, 8'ha0, "reload low");
    rd_chk(timer_pkg::IDX_UPPER_ZERO, 8'ha0, "reload high");
    $display("test reload8 done");
    // unit one counts its pin, qualified by its irq pin
    wr(timer_pkg::IDX_MODE_CFG, 8'hd0);
    wr(timer_pkg::IDX_LOW_ONE, 8'h05);
    wr(timer_pkg::IDX_UPPER_ONE, 8'h00);
    ext_irq_pin_one <= 1'b0;
    wr(timer_pkg::IDX_RUN_FLAG, 8'h40);
    pulse(4'h2);
    rd_chk(timer_pkg::IDX_LOW_ONE, 8'h05, "gated hold");
    ext_irq_pin_one <= 1'b1;
    idle(12);
    pulse(4'h3);
    rd_chk(timer_pkg::IDX_LOW_ONE, 8'h08, "pin count");
    $display("test counter done");
    wr(timer_pkg::IDX_MODE_CFG, 8'h30);
    wr(timer_pkg::IDX_RUN_FLAG, 8'h40);
    idle(30);
    rd_chk(timer_pkg::IDX_LOW_ONE, 8'h08, "unit one hold");
    // split: upper zero borrows unit one run bit and flag
    wr(timer_pkg::IDX_MODE_CFG, 8'h13);
    wr(timer_pkg::IDX_LOW_ZERO, 8'h00);
    wr(timer_pkg::IDX_UPPER_ZERO, 8'hfe);
    idle(20);
    chk({7'h0, run_flag_reg.overflow_flag_one}, 8'h01, "split ovf");
    rd_chk(timer_pkg::IDX_LOW_ZERO, 8'h00, "split low idle");
    bus(timer_pkg::IDX_LOW_ONE, 1'b0, 8'h00, q);
    chk(8'(q > 8'h08), 8'h01, "unit one runs");
    $display("test split done");
    wr(timer_pkg::IDX_RUN_FLAG, 8'h01);
    ext_irq_pin_zero <= 1'b0;
    idle(20);
    chk({7'h0, run_flag_reg.ext_irq_flag_zero}, 8'h01, "edge flag");
    wr(timer_pkg::IDX_RUN_FLAG, 8'h01);
    idle(14);
    chk({7'h0, run_flag_reg.ext_irq_flag_zero}, 8'h00, "edge once");
    wr(timer_pkg::IDX_RUN_FLAG, 8'h00);
    idle(14);
    chk({7'h0, run_flag_reg.ext_irq_flag_zero}, 8'h01, "level flag");
    ext_irq_pin_zero <= 1'b1;
    $display("test ext irq done");
    // unit one reloads at once; unit zero counts pin falls
    wr(timer_pkg::IDX_MODE_CFG, 8'h25);
    wr(timer_pkg::IDX_LOW_ZERO, 8'h10);
    wr(timer_pkg::IDX_UPPER_ZERO, 8'h00);
    wr(timer_pkg::IDX_LOW_ONE, 8'hff);
    wr(timer_pkg::IDX_UPPER_ONE, 8'h33);
    wr(timer_pkg::IDX_RUN_FLAG, 8'h50);
    wait_ovf(1'b1, 20, n);
    chk({7'h0, run_flag_reg.overflow_flag_one}, 8'h01, "ovf flag one");
    pulse(4'h2);
    rd_chk(timer_pkg::IDX_LOW_ZERO, 8'h12, "pin zero count");
    $display("test unit pair done");
    close_out();
  end
endmodule
